// ===== shared/ptc_pkg.sv
// Register map, field layout and state types for the timer compare block
package ptc_pkg;

  // I/O addresses
  localparam logic [5:0] ADDR_DT    = 6'h24;
  localparam logic [5:0] ADDR_FLAGS = 6'h38;
  localparam logic [5:0] ADDR_MASK  = 6'h39;
  localparam logic [5:0] ADDR_CMP_D = 6'h2e;
  localparam logic [5:0] ADDR_HB    = 6'h2f;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [9:0] RST_CMP  = 10'h000;
  localparam logic [1:0] RST_HB   = 2'h0;

  // Flag index inside the block, and bit position in flag and mask bytes
  localparam int NUM_FLAGS = 4;
  localparam int IDX_OV    = 0;
  localparam int IDX_B     = 1;
  localparam int IDX_A     = 2;
  localparam int IDX_D     = 3;
  localparam logic [2:0] POS_OV = 3'h2;
  localparam logic [2:0] POS_B  = 3'h5;
  localparam logic [2:0] POS_A  = 3'h6;
  localparam logic [2:0] POS_D  = 3'h7;

  // Dead-time fields
  localparam int DT_W      = 4;
  localparam int DT_HI_LSB = 4;
  localparam int DT_LO_LSB = 0;

  // Wave mode bit that selects overflow at BOTTOM in PWM
  localparam int WAVE_DUAL_BIT = 0;

  // Complementary output channels
  localparam int NUM_PWM = 3;

  // Match to flag synchronisation delay, in clock cycles
  localparam int SYNC_CYC = 1;

  typedef enum logic [1:0] {
    DT_LO_ON,
    DT_WAIT_HI,
    DT_HI_ON,
    DT_WAIT_LO
  } ptc_dt_state_e;

endpackage : ptc_pkg

// ===== shared/ptc_dt_if.sv
// Carrier between the register block and one dead-time generator
`timescale 1ns/1ps
`default_nettype none

interface ptc_dt_if;
  logic       tick;
  logic [3:0] dt_hi;
  logic [3:0] dt_lo;
  logic       pwm_in;
  logic       out_hi;
  logic       out_lo;

  modport ctl (output tick, output dt_hi, output dt_lo, output pwm_in,
               input out_hi, input out_lo);
  modport gen (input tick, input dt_hi, input dt_lo, input pwm_in,
               output out_hi, output out_lo);
endinterface : ptc_dt_if

`default_nettype wire

// ===== hw/ptc_dead_time.sv
// Dead-time generator for one complementary output pair
`timescale 1ns/1ps
`default_nettype none

module ptc_dead_time
  import ptc_pkg::*;
(
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // Settings, level and pair
  ptc_dt_if.gen     dt
);

  ptc_dt_state_e  st_ff;
  logic [DT_W-1:0] cnt_ff;

  // Rising side waits its own count of timer ticks
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff     <= DT_WAIT_LO;
      cnt_ff    <= '0;
      dt.out_hi <= 1'b0;
      dt.out_lo <= 1'b0;
    end else begin
      case (st_ff)
        DT_LO_ON: begin
          if (dt.pwm_in) begin
            dt.out_lo <= 1'b0;
            cnt_ff    <= dt.dt_hi;
            st_ff     <= DT_WAIT_HI;
          end
        end
        DT_WAIT_HI: begin
          if (!dt.pwm_in) begin
            cnt_ff <= dt.dt_lo;
            st_ff  <= DT_WAIT_LO;
          end else if (cnt_ff == '0) begin
            dt.out_hi <= 1'b1;
            st_ff     <= DT_HI_ON;
          end else if (dt.tick) begin
            cnt_ff <= cnt_ff - 1'b1;
          end
        end
        DT_HI_ON: begin
          if (!dt.pwm_in) begin
            dt.out_hi <= 1'b0;
            cnt_ff    <= dt.dt_lo;
            st_ff     <= DT_WAIT_LO;
          end
        end
        DT_WAIT_LO: begin
          if (dt.pwm_in) begin
            cnt_ff <= dt.dt_hi;
            st_ff  <= DT_WAIT_HI;
          end else if (cnt_ff == '0) begin
            dt.out_lo <= 1'b1;
            st_ff     <= DT_LO_ON;
          end else if (dt.tick) begin
            cnt_ff <= cnt_ff - 1'b1;
          end
        end
        default: begin
          st_ff <= DT_WAIT_LO;
        end
      endcase
    end
  end

  a_dt_no_overlap: assert property (
    @(posedge ref_clk) disable iff (!rst_n) !(dt.out_hi && dt.out_lo)
  ) else $error("both sides of pair high");

endmodule : ptc_dead_time

`default_nettype wire

// ===== hw/ptc_timer_irq.sv
// Compare channel D, interrupt mask and flags, dead-time values and pairs
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Channel D compare value is readable, writable, compared on every timer clock.
// - Match D counts only when the counter steps onto the value.
// - Software making counter and compare D equal gives no match.
// - Match D sets flag bit 7 after one sync cycle.
// - Request D when mask bit 7, global enable and flag D set.
// - Request A when mask bit 6, global enable and flag A set.
// - Request B when mask bit 5, global enable and flag B set.
// - Request overflow when mask bit 2, global enable and flag set.
// - Matches on A and B set flag bits 6 and 5.
// - Executing a vector clears its flag.
// - Writing one clears a flag one cycle later; zero leaves it.
// - Normal and fast PWM set overflow when counter wraps TOP to BOTTOM.
// - Dual-slope PWM sets overflow when zero is loaded at BOTTOM.
// - Dead-time byte: bits 7:4 high side, bits 3:0 low side.
// - Each dead time counts 0 to 15 timer ticks before rising.
// - One pair of dead-time settings serves every output channel.
// - Mask, flags, dead-time and compare D reset to zero.
// - Upper two bits of 10-bit accesses pass the shared staging register.
// - Match on the top compare value clears the counter.
module ptc_timer_irq
  import ptc_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // CPU I/O register port
  input  wire logic [5:0] io_addr,
  input  wire logic       io_wr,
  input  wire logic       io_rd,
  input  wire logic [7:0] io_wdata,
  output logic      [7:0] io_rdata,
  // CPU interrupt side
  input  wire logic       cpu_irq_enable,
  input  wire logic [3:0] vec_ack,
  output logic      [3:0] irq_req,
  // Counter core
  input  wire logic       tmr_tick,
  input  wire logic       count_step,
  input  wire logic [9:0] counter_value,
  input  wire logic [9:0] compare_value_a,
  input  wire logic [9:0] compare_value_b,
  input  wire logic [9:0] top_compare_value,
  input  wire logic       pwm_enable,
  input  wire logic [1:0] wave_mode,
  input  wire logic       top_wrap,
  input  wire logic       bottom_load,
  output logic            top_clear,
  output logic      [9:0] compare_value_d,
  // Complementary output pairs
  input  wire logic [2:0] pwm_level,
  output wire logic [2:0] pwm_pair_hi,
  output wire logic [2:0] pwm_pair_lo
);

  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic [7:0] mask_ff;
  logic [7:0] dt_ff;
  logic [9:0] cmp_d_ff;
  logic [1:0] hb_ff;
  logic [3:0] flg_ff;
  logic [3:0] clr_pend_ff;
  logic [3:0] mt_ff;
  logic [3:0] irq_ff;
  logic       top_clr_ff;
  logic       ovf_now;
  logic       wr_flags;
  logic       wr_cmp;
  logic       rd_cmp;
  wire  [3:0] mt_now;
  wire  [3:0] set_ev;
  wire  [3:0] nxt_flg;
  wire  [9:0] cmp_val [NUM_FLAGS];

  // Bit position of a flag in the flag and mask bytes
  function automatic logic [2:0] flag_pos(input int idx);
    case (idx)
      IDX_D:   flag_pos = POS_D;
      IDX_A:   flag_pos = POS_A;
      IDX_B:   flag_pos = POS_B;
      default: flag_pos = POS_OV;
    endcase
  endfunction : flag_pos

  // Flag byte as software reads it; other bits read zero
  function automatic logic [7:0] flag_byte(input logic [3:0] f);
    flag_byte = 8'h00;
    for (int i = 0; i < NUM_FLAGS; i++) begin
      flag_byte[flag_pos(i)] = f[i];
    end
  endfunction : flag_byte

  assign io_rdata        = rdata_ff;
  assign irq_req         = irq_ff;
  assign top_clear       = top_clr_ff;
  assign compare_value_d = cmp_d_ff;

  assign wr_flags = io_wr && (io_addr == ADDR_FLAGS);
  assign wr_cmp   = io_wr && (io_addr == ADDR_CMP_D);
  assign rd_cmp   = io_rd && (io_addr == ADDR_CMP_D);

  // Overflow point depends on the waveform mode
  always_comb begin
    if (pwm_enable && wave_mode[WAVE_DUAL_BIT]) begin
      ovf_now = bottom_load;
    end else begin
      ovf_now = top_wrap;
    end
  end

  assign cmp_val[IDX_OV] = top_compare_value;
  assign cmp_val[IDX_B]  = compare_value_b;
  assign cmp_val[IDX_A]  = compare_value_a;
  assign cmp_val[IDX_D]  = cmp_d_ff;

  // Only a counting step can land on a compare value
  generate
    for (genvar i = 0; i < NUM_FLAGS; i++) begin : g_match
      assign mt_now[i] = count_step && (counter_value == cmp_val[i]);
    end
  endgenerate

  // Matches pass the sync stage, overflow sets directly
  assign set_ev = {mt_ff[IDX_D], mt_ff[IDX_A], mt_ff[IDX_B], ovf_now};

  generate
    for (genvar i = 0; i < NUM_FLAGS; i++) begin : g_flag
      // Set wins over write-one and vector clears
      assign nxt_flg[i] = set_ev[i] || (flg_ff[i] && !clr_pend_ff[i] && !vec_ack[i]);
    end
  endgenerate

  // Match sync stage and top clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mt_ff      <= 4'h0;
      top_clr_ff <= 1'b0;
    end else begin
      mt_ff      <= mt_now;
      top_clr_ff <= mt_now[IDX_OV];
    end
  end

  // Interrupt flags
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flg_ff      <= 4'h0;
      clr_pend_ff <= 4'h0;
    end else begin
      flg_ff <= nxt_flg;
      for (int i = 0; i < NUM_FLAGS; i++) begin
        clr_pend_ff[i] <= wr_flags && io_wdata[flag_pos(i)];
      end
    end
  end

  // Interrupt requests gated by mask and global enable
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_ff <= 4'h0;
    end else begin
      for (int i = 0; i < NUM_FLAGS; i++) begin
        irq_ff[i] <= flg_ff[i] && mask_ff[flag_pos(i)] && cpu_irq_enable;
      end
    end
  end

  // Mask and dead-time registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_ff <= RST_BYTE;
      dt_ff   <= RST_BYTE;
    end else if (io_wr) begin
      if (io_addr == ADDR_MASK) begin
        mask_ff <= io_wdata;
      end
      if (io_addr == ADDR_DT) begin
        dt_ff <= io_wdata;
      end
    end
  end

  // Compare D and the shared high-byte staging register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_d_ff <= RST_CMP;
      hb_ff    <= RST_HB;
    end else begin
      if (wr_cmp) begin
        cmp_d_ff <= {hb_ff, io_wdata};
      end
      if (io_wr && (io_addr == ADDR_HB)) begin
        hb_ff <= io_wdata[1:0];
      end else if (rd_cmp) begin
        hb_ff <= cmp_d_ff[9:8];
      end
    end
  end

  // Read data mux; unmapped reads return zero
  always_comb begin
    nxt_rdata = 8'h00;
    case (io_addr)
      ADDR_DT:    nxt_rdata = dt_ff;
      ADDR_FLAGS: nxt_rdata = flag_byte(flg_ff);
      ADDR_MASK:  nxt_rdata = mask_ff;
      ADDR_CMP_D: nxt_rdata = cmp_d_ff[7:0];
      ADDR_HB:    nxt_rdata = {6'h00, hb_ff};
      default:    nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= RST_BYTE;
    end else if (io_rd) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // One dead-time generator per channel, all on the same settings
  generate
    for (genvar c = 0; c < NUM_PWM; c++) begin : g_dt
      ptc_dt_if dti ();
      assign dti.tick       = tmr_tick;
      assign dti.dt_hi      = dt_ff[DT_HI_LSB +: DT_W];
      assign dti.dt_lo      = dt_ff[DT_LO_LSB +: DT_W];
      assign dti.pwm_in     = pwm_level[c];
      assign pwm_pair_hi[c] = dti.out_hi;
      assign pwm_pair_lo[c] = dti.out_lo;
      ptc_dead_time u_dt (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .dt      (dti.gen)
      );
    end
  endgenerate

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  a_match_d_flag: assert property (
    count_step && counter_value == compare_value_d |-> ##2 flg_ff[IDX_D]
  ) else $error("match D flag not set two cycles after match");

  a_write_no_match: assert property (
    !count_step |=> !mt_ff[IDX_D] && !mt_ff[IDX_A]
  ) else $error("match seen without a counting step");

  a_irq_d_gate: assert property (
    irq_req[IDX_D] |-> $past(mask_ff[POS_D] && cpu_irq_enable && flg_ff[IDX_D])
  ) else $error("request D without mask, enable and flag");

  a_irq_a_mask: assert property (
    !mask_ff[POS_A] |=> !irq_req[IDX_A]
  ) else $error("request A while masked");

  a_irq_b_global: assert property (
    !cpu_irq_enable |=> !irq_req[IDX_B]
  ) else $error("request B while globally disabled");

  a_irq_ov_raise: assert property (
    flg_ff[IDX_OV] && mask_ff[POS_OV] && cpu_irq_enable |=> irq_req[IDX_OV]
  ) else $error("overflow request not raised");

  a_w1c_clear: assert property (
    wr_flags && io_wdata[POS_D] ##1 !mt_ff[IDX_D] |=> !flg_ff[IDX_D]
  ) else $error("write one did not clear flag D");

  a_set_wins: assert property (
    mt_ff[IDX_A] && (clr_pend_ff[IDX_A] || vec_ack[IDX_A]) |=> flg_ff[IDX_A]
  ) else $error("clear beat a set on flag A");

  a_vec_clear: assert property (
    vec_ack[IDX_B] && !mt_ff[IDX_B] |=> !flg_ff[IDX_B]
  ) else $error("vector did not clear flag B");

  a_ovf_top: assert property (
    top_wrap && !(pwm_enable && wave_mode[WAVE_DUAL_BIT]) |=> flg_ff[IDX_OV]
  ) else $error("overflow not set at TOP");

  a_ovf_bottom: assert property (
    bottom_load && pwm_enable && wave_mode[WAVE_DUAL_BIT] |=> flg_ff[IDX_OV]
  ) else $error("overflow not set at BOTTOM");

  a_top_clear: assert property (
    count_step && counter_value == top_compare_value |=> top_clear
  ) else $error("top match did not clear counter");

  a_hb_on_read: assert property (
    rd_cmp && !io_wr |=> hb_ff == $past(compare_value_d[9:8])
  ) else $error("staging not loaded on compare D read");

  a_set_wins_d: assert property (
    mt_ff[IDX_D] && (clr_pend_ff[IDX_D] || vec_ack[IDX_D]) |=> flg_ff[IDX_D]
  ) else $error("clear beat a set on flag D");

  a_vec_clear_d: assert property (
    vec_ack[IDX_D] && !mt_ff[IDX_D] |=> !flg_ff[IDX_D]
  ) else $error("vector did not clear flag D");

  a_zero_write_keep: assert property (
    wr_flags && !io_wdata[POS_D] |=> !clr_pend_ff[IDX_D]
  ) else $error("zero write armed a clear of flag D");

  a_irq_d_raise: assert property (
    flg_ff[IDX_D] && mask_ff[POS_D] && cpu_irq_enable |=> irq_req[IDX_D]
  ) else $error("request D not raised");

  a_irq_a_raise: assert property (
    flg_ff[IDX_A] && mask_ff[POS_A] && cpu_irq_enable |=> irq_req[IDX_A]
  ) else $error("request A not raised");

  a_irq_b_raise: assert property (
    flg_ff[IDX_B] && mask_ff[POS_B] && cpu_irq_enable |=> irq_req[IDX_B]
  ) else $error("request B not raised");

  a_match_a_flag: assert property (
    count_step && counter_value == compare_value_a |-> ##2 flg_ff[IDX_A]
  ) else $error("match A flag not set two cycles after match");

  a_match_b_flag: assert property (
    count_step && counter_value == compare_value_b |-> ##2 flg_ff[IDX_B]
  ) else $error("match B flag not set two cycles after match");

  a_ovf_dual_hold: assert property (
    pwm_enable && wave_mode[WAVE_DUAL_BIT] && !bottom_load && !flg_ff[IDX_OV] |=> !flg_ff[IDX_OV]
  ) else $error("overflow set away from BOTTOM in dual slope");

  a_dt_write: assert property (
    io_wr && io_addr == ADDR_DT |=> dt_ff == $past(io_wdata)
  ) else $error("dead-time byte not stored");

  a_cmp_d_write: assert property (
    wr_cmp |=> compare_value_d == {$past(hb_ff), $past(io_wdata)}
  ) else $error("compare D not loaded from staging and low byte");

endmodule : ptc_timer_irq

`default_nettype wire

// ===== sim/tb.sv
// Register-level bench for the timer compare, interrupt and dead-time block
`timescale 1ns/1ps
`default_nettype none

module tb
  import ptc_pkg::*;
;
  logic       ref_clk           = 1'b0;
  logic       rst_n             = 1'b0;
  logic [5:0] io_addr           = 6'h00;
  logic       io_wr             = 1'b0;
  logic       io_rd             = 1'b0;
  logic [7:0] io_wdata          = 8'h00;
  wire  [7:0] io_rdata;
  logic       cpu_irq_enable    = 1'b0;
  logic [3:0] vec_ack           = 4'h0;
  wire  [3:0] irq_req;
  logic       tmr_tick          = 1'b1;
  logic       count_step        = 1'b0;
  logic [9:0] counter_value     = 10'h000;
  logic [9:0] compare_value_a   = 10'h100;
  logic [9:0] compare_value_b   = 10'h180;
  logic [9:0] top_compare_value = 10'h200;
  logic       pwm_enable        = 1'b0;
  logic [1:0] wave_mode         = 2'h0;
  logic       top_wrap          = 1'b0;
  logic       bottom_load       = 1'b0;
  wire        top_clear;
  wire  [9:0] compare_value_d;
  logic [2:0] pwm_level         = 3'h0;
  wire  [2:0] pwm_pair_hi;
  wire  [2:0] pwm_pair_lo;
  int         num_errors        = 0;
  int         compares          = 0;
  logic [7:0] fexp [6]          = '{8'h40, 8'h20, 8'h04, 8'h00, 8'h04, 8'h00};
  logic [3:0] iexp [6]          = '{4'h4, 4'h2, 4'h1, 4'h0, 4'h1, 4'h0};

  ptc_timer_irq uut (
    .ref_clk, .rst_n, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata,
    .cpu_irq_enable, .vec_ack, .irq_req, .tmr_tick, .count_step, .counter_value,
    .compare_value_a, .compare_value_b, .top_compare_value, .pwm_enable, .wave_mode,
    .top_wrap, .bottom_load, .top_clear, .compare_value_d, .pwm_level, .pwm_pair_hi,
    .pwm_pair_lo
  );

  always #2.5 ref_clk = ~ref_clk;

  task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    io_addr  = a;
    io_wdata = d;
    io_wr    = 1'b1;
    @(negedge ref_clk);
    io_wr = 1'b0;
    // Strobe stays low for one edge between accesses
    @(negedge ref_clk);
  endtask : wr

  task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp, input string what);
    io_addr = a;
    io_rd   = 1'b1;
    @(negedge ref_clk);
    io_rd = 1'b0;
    check(what, {2'h0, io_rdata}, {2'h0, exp});
    @(negedge ref_clk);
  endtask : rd_chk

  // Counter moves onto a value by counting
  task automatic step(input logic [9:0] v);
    counter_value = v;
    count_step    = 1'b1;
    @(negedge ref_clk);
    count_step = 1'b0;
  endtask : step

  task automatic fire(input int k);
    if (k < 2) begin
      step((k == 0) ? compare_value_a : compare_value_b);
    end else begin
      top_wrap    = (k == 2 || k == 5);
      bottom_load = (k == 3 || k == 4);
      @(negedge ref_clk);
      top_wrap    = 1'b0;
      bottom_load = 1'b0;
    end
  endtask : fire

  // Counts cycles until the new level shows on every pair
  task automatic dt_run(input logic [2:0] lvl, input int n);
    int k;
    k         = 0;
    pwm_level = lvl;
    while (k < 40 && ((lvl == 3'h7) ? (pwm_pair_hi !== 3'h7) : (pwm_pair_lo !== 3'h7))) begin
      @(negedge ref_clk);
      k++;
      check("pair overlap", {7'h0, pwm_pair_hi & pwm_pair_lo}, 10'h000);
    end
    check("dead time cycles", k[9:0], n[9:0]);
  endtask : dt_run

  task automatic wrap_up;
    $display("compares %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    #20000;
    num_errors++;
    wrap_up();
  end

  initial begin
    cyc(5);
    rst_n = 1'b1;
    rd_chk(ADDR_DT, RST_BYTE, "dead time reset");
    rd_chk(ADDR_FLAGS, RST_BYTE, "flags reset");
    rd_chk(ADDR_MASK, RST_BYTE, "mask reset");
    rd_chk(ADDR_CMP_D, RST_BYTE, "compare d reset");
    check("compare d reset value", compare_value_d, RST_CMP);
    rd_chk(6'h3f, 8'h00, "unmapped read");
    $display("test reset values done");

    wr(ADDR_DT, 8'ha5);
    rd_chk(ADDR_DT, 8'ha5, "dead time readback");
    wr(ADDR_MASK, 8'he4);
    rd_chk(ADDR_MASK, 8'he4, "mask readback");
    wr(ADDR_HB, 8'h02);
    wr(ADDR_CMP_D, 8'h34);
    check("compare d value", compare_value_d, 10'h234);
    wr(ADDR_HB, 8'h01);
    rd_chk(ADDR_CMP_D, 8'h34, "compare d low byte");
    rd_chk(ADDR_HB, 8'h02, "staging high bits");
    $display("test registers done");

    counter_value = 10'h234;
    cyc(4);
    rd_chk(ADDR_FLAGS, 8'h00, "flags after software equality");
    step(10'h233);
    cyc(2);
    rd_chk(ADDR_FLAGS, 8'h00, "flags off compare value");
    step(10'h234);
    cyc(2);
    rd_chk(ADDR_FLAGS, 8'h80, "flag d after match");
    check("request without global enable", {6'h0, irq_req}, 10'h000);
    cpu_irq_enable = 1'b1;
    cyc(2);
    check("request d", {6'h0, irq_req}, 10'h008);
    wr(ADDR_MASK, 8'h64);
    cyc(2);
    check("request d masked", {6'h0, irq_req}, 10'h000);
    wr(ADDR_MASK, 8'he4);
    wr(ADDR_FLAGS, 8'h00);
    cyc(1);
    rd_chk(ADDR_FLAGS, 8'h80, "flag after zero write");
    wr(ADDR_FLAGS, 8'h80);
    cyc(1);
    rd_chk(ADDR_FLAGS, 8'h00, "flag after one write");
    // Match and write-one clear taken at the same edge
    count_step = 1'b1;
    io_addr    = ADDR_FLAGS;
    io_wdata   = 8'h80;
    io_wr      = 1'b1;
    cyc(1);
    count_step = 1'b0;
    io_wr      = 1'b0;
    cyc(2);
    rd_chk(ADDR_FLAGS, 8'h80, "set against clear");
    vec_ack = 4'h8;
    cyc(1);
    vec_ack = 4'h0;
    cyc(2);
    rd_chk(ADDR_FLAGS, 8'h00, "flag d after vector");
    check("request d after vector", {6'h0, irq_req}, 10'h000);
    $display("test channel d done");

    for (int k = 0; k < 6; k++) begin
      pwm_enable = (k >= 4);
      wave_mode  = 2'h1;
      fire(k);
      cyc(2);
      rd_chk(ADDR_FLAGS, fexp[k], "flag after event");
      check("request after event", {6'h0, irq_req}, {6'h0, iexp[k]});
      vec_ack = iexp[k];
      cyc(1);
      vec_ack = 4'h0;
      cyc(2);
      rd_chk(ADDR_FLAGS, 8'h00, "flag after vector");
    end
    $display("test flags and overflow done");

    step(10'h1ff);
    check("no top clear", {9'h0, top_clear}, 10'h000);
    cyc(1);
    step(10'h200);
    check("top clear pulse", {9'h0, top_clear}, 10'h001);
    cyc(1);
    check("top clear ends", {9'h0, top_clear}, 10'h000);
    $display("test top clear done");

    dt_run(3'h7, 12);
    dt_run(3'h0, 7);
    wr(ADDR_DT, 8'h00);
    dt_run(3'h7, 2);
    dt_run(3'h0, 2);
    wr(ADDR_DT, 8'hf0);
    dt_run(3'h7, 17);
    // Without timer ticks the wait does not advance
    wr(ADDR_DT, 8'h0f);
    tmr_tick = 1'b0;
    dt_run(3'h0, 40);
    tmr_tick = 1'b1;
    dt_run(3'h0, 16);
    $display("test dead time done");
    wrap_up();
  end
endmodule : tb

`default_nettype wire
